// ---- src/ctrl_reg_decode.sv ----
// Device end: control-space frame decode and main control register
`timescale 1ns/1ps

module ctrl_reg_decode #(
   parameter int CHANNELS = 4,
   parameter logic [1:0] DEV_ADDR = 2'h0
) (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic nrst, // Async reset, active low
   ctrl_frame_if.dev link, // Frame port from host
   input wire logic poc_pin, // Power-on-condition pin, async
   output logic [CHANNELS-1:0] chan_idle_level, // Level for disabled outputs
   output logic [CHANNELS-1:0] chan_out_en, // Effective output enable
   output logic [CHANNELS-1:0] chan_conv_pwr, // Effective converter power
   output logic [12:0] main_ctrl, // Main control register contents
   output logic status_rb_en, // Status readback during write
   output logic watchdog_en, // Watchdog timer enable
   output logic [31:0] watchdog_cycles, // Selected timeout in clocks
   output logic short_limit_8ma, // 1 selects 8 mA limit
   output logic [12:0] slew_r [CHANNELS], // Slew registers, raw
   output logic [12:0] dac_ctrl_r [CHANNELS], // DAC control, raw
   output logic [12:0] converter_r, // Converter control, raw
   output logic [12:0] software_r // Software register, raw
);
   import ctrl_frame_pkg::*;

   // Channel address is two bits wide, so only four channels can be served
   if (CHANNELS != 4) begin : g_chan_check
      $error("CHANNELS must be 4");
   end

   logic [12:0] main_control_r;
   logic poc_meta_r;
   logic poc_sync_r;
   logic hit;
   logic wr_ok;
   logic [2:0] sel;
   logic [1:0] chan;
   logic [12:0] wdata;

   // Decode fields of the frame
   assign sel = link.frame[SEL_HI:SEL_LO];
   assign chan = link.frame[CHAN_HI:CHAN_LO];
   assign wdata = link.frame[DATA_HI:0];
   // Write access to control space of this device
   assign hit = link.frame_valid && !link.frame[RW_BIT]
      && link.frame[DEV_HI:DEV_LO] == DEV_ADDR
      && link.frame[GRP_HI:GRP_LO] == GRP_CONTROL;
   // Codes 5 to 7 name no register, so such frames write nothing
   assign wr_ok = hit && sel <= SEL_SOFTWARE;
   // Always ready: decode is single-cycle
   assign link.frame_ready = 1'b1;

   // Main control register; don't-care bits never stored
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         main_control_r <= MC_RESET;
      end else if (wr_ok && sel == SEL_MAIN) begin
         main_control_r <= wdata & MC_WMASK;
      end
   end

   // Slew registers, one per channel, picked by the channel address
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            slew_r[i] <= 13'h0000;
         end
      end else if (wr_ok && sel == SEL_SLEW) begin
         slew_r[chan] <= wdata;
      end
   end

   // DAC control registers; only the addressed channel changes
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < CHANNELS; i++) begin
            dac_ctrl_r[i] <= 13'h0000;
         end
      end else if (wr_ok && sel == SEL_DAC_CTRL) begin
         dac_ctrl_r[chan] <= wdata;
      end
   end

   // Converter register, one copy shared by all channels
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         converter_r <= 13'h0000;
      end else if (wr_ok && sel == SEL_CONVERTER) begin
         converter_r <= wdata;
      end
   end

   // Software register, stored raw; its fields are decoded elsewhere
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         software_r <= 13'h0000;
      end else if (wr_ok && sel == SEL_SOFTWARE) begin
         software_r <= wdata;
      end
   end

   // Readback strobe, one cycle after each frame while enabled
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         link.status_valid <= 1'b0;
      end else begin
         link.status_valid <= link.frame_valid && main_control_r[MC_STATUS_RB];
      end
   end

   // Readback word: contents before this frame's write land
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         link.status_word <= 13'h0000;
      end else begin
         link.status_word <= main_control_r;
      end
   end

   // Pin synchroniser
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         poc_meta_r <= 1'b0;
         poc_sync_r <= 1'b0;
      end else begin
         poc_meta_r <= poc_pin;
         poc_sync_r <= poc_meta_r;
      end
   end

   // Idle level per channel; XOR gives pin level at 0, inverse at 1
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chan_idle_level <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            chan_idle_level[i] <= poc_sync_r ^ main_control_r[MC_POLARITY];
         end
      end
   end

   // Output enable: the all-channel bit overrides each channel's own bit
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chan_out_en <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            chan_out_en[i] <= main_control_r[MC_OUT_ALL] | dac_ctrl_r[i][DAC_OUT_EN];
         end
      end
   end

   // Converter power; clearing the all bit leaves per-channel power alone
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         chan_conv_pwr <= '0;
      end else begin
         for (int i = 0; i < CHANNELS; i++) begin
            chan_conv_pwr[i] <= main_control_r[MC_CONV_ALL] | dac_ctrl_r[i][DAC_CONV_PWR];
         end
      end
   end

   // Field views
   assign main_ctrl = main_control_r;
   assign status_rb_en = main_control_r[MC_STATUS_RB];
   assign watchdog_en = main_control_r[MC_WD_EN];
   assign short_limit_8ma = main_control_r[MC_SHORT_LIM];

   // Timeout in clocks from period code
   always_comb begin
      unique case (main_control_r[MC_WD_HI:MC_WD_LO])
         2'h0: watchdog_cycles = 32'(WD_MS_0 * CYC_PER_MS);
         2'h1: watchdog_cycles = 32'(WD_MS_1 * CYC_PER_MS);
         2'h2: watchdog_cycles = 32'(WD_MS_2 * CYC_PER_MS);
         2'h3: watchdog_cycles = 32'(WD_MS_3 * CYC_PER_MS);
      endcase
   end
endmodule

// ---- common/ctrl_frame_pkg.sv ----
// Package: frame layout, select codes, main control field positions and timing
package ctrl_frame_pkg;
   localparam int FRAME_W = 24;
   localparam int RW_BIT = 23;
   localparam int DEV_HI = 22;
   localparam int DEV_LO = 21;
   localparam int GRP_HI = 20;
   localparam int GRP_LO = 18;
   localparam int CHAN_HI = 17;
   localparam int CHAN_LO = 16;
   localparam int SEL_HI = 15;
   localparam int SEL_LO = 13;
   localparam int DATA_HI = 12;
   localparam logic [2:0] GRP_CONTROL = 3'h7;
   localparam logic [2:0] SEL_SLEW = 3'h0;
   localparam logic [2:0] SEL_MAIN = 3'h1;
   localparam logic [2:0] SEL_DAC_CTRL = 3'h2;
   localparam logic [2:0] SEL_CONVERTER = 3'h3;
   localparam logic [2:0] SEL_SOFTWARE = 3'h4;
   // Main control data field positions
   localparam int MC_POLARITY = 12;
   localparam int MC_STATUS_RB = 11;
   localparam int MC_WD_EN = 10;
   localparam int MC_WD_HI = 9;
   localparam int MC_WD_LO = 8;
   localparam int MC_SHORT_LIM = 6;
   localparam int MC_OUT_ALL = 5;
   localparam int MC_CONV_ALL = 4;
   localparam logic [12:0] MC_WMASK = 13'h1F70;
   localparam logic [12:0] MC_RESET = 13'h0000;
   // Per-channel DAC control bits that feed the effective enables
   localparam int DAC_OUT_EN = 5;
   localparam int DAC_CONV_PWR = 4;
   // Watchdog periods in ms per code
   localparam int WD_MS_0 = 5;
   localparam int WD_MS_1 = 10;
   localparam int WD_MS_2 = 100;
   localparam int WD_MS_3 = 200;
   localparam int SYS_CLK_HZ = 40_000_000;
   localparam int CYC_PER_MS = SYS_CLK_HZ / 1000;
   // Host register map (AXI4-Lite byte offsets)
   localparam logic [3:0] A_FRAME = 4'h0;
   localparam logic [3:0] A_STATUS = 4'h4;
   localparam logic [3:0] A_IRQ_STAT = 4'h8;
   localparam logic [3:0] A_IRQ_MASK = 4'hC;
   localparam int IRQ_DONE = 0;
   localparam int IRQ_SEQ_ERR = 1;
endpackage

// ---- common/ctrl_frame_if.sv ----
// Interface: one-word frame strobe between host controller and device
`timescale 1ns/1ps
interface ctrl_frame_if;
   logic frame_valid;
   logic [23:0] frame;
   logic frame_ready;
   logic [12:0] status_word;
   logic status_valid;
   modport dev (input frame_valid, input frame, output frame_ready,
      output status_word, output status_valid);
   modport host (output frame_valid, output frame, input frame_ready,
      input status_word, input status_valid);
endinterface

// ---- src/ctrl_frame_host.sv ----
// Host end: AXI4-Lite command registers driving frames to the device
`timescale 1ns/1ps
module ctrl_frame_host (
   input wire logic sys_clk, // 40 MHz clock
   input wire logic nrst, // Async reset, active low
   ctrl_frame_if.host link, // Frame port to device
   input wire logic [3:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Byte strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Response ready
   input wire logic [3:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read valid
   input wire logic s_axi_rready, // Read ready
   output logic irq // Level interrupt
);
   import ctrl_frame_pkg::*;

   logic [3:0] awaddr_r;
   logic aw_have_r;
   logic [31:0] wdata_r;
   logic w_have_r;
   logic [23:0] frame_r;
   logic busy_r;
   logic [12:0] last_status_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [1:0] ev;
   logic do_wr;
   logic frame_done;

   assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
   assign s_axi_wready = !w_have_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign s_axi_bresp = 2'h0;
   assign s_axi_rresp = 2'h0;
   assign do_wr = aw_have_r && w_have_r && !s_axi_bvalid;
   assign frame_done = busy_r && link.frame_ready;
   // Events: frame sent; frame write while busy
   assign ev[IRQ_DONE] = frame_done;
   assign ev[IRQ_SEQ_ERR] = do_wr && awaddr_r == A_FRAME && busy_r;
   assign link.frame_valid = busy_r;
   assign link.frame = frame_r;
   assign irq = |(irq_stat_r & irq_mask_r);

   // Capture address and data in either order
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         aw_have_r <= 1'b0;
         w_have_r <= 1'b0;
         awaddr_r <= 4'h0;
         wdata_r <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Frame launch; one frame held until device takes it
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         busy_r <= 1'b0;
         frame_r <= 24'h00_0000;
      end else if (frame_done) begin
         busy_r <= 1'b0;
      end else if (do_wr && awaddr_r == A_FRAME && s_axi_wstrb == 4'hF) begin
         busy_r <= 1'b1;
         // Software owns ordering of converter and output bits
         frame_r <= wdata_r[FRAME_W-1:0];
      end
   end

   // Last status word returned by device
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         last_status_r <= 13'h0000;
      end else if (link.status_valid) begin
         last_status_r <= link.status_word;
      end
   end

   // Sticky status, write one to clear; set wins
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         irq_stat_r <= 2'h0;
         irq_mask_r <= 2'h0;
      end else begin
         if (do_wr && awaddr_r == A_IRQ_STAT && s_axi_wstrb[0]) begin
            irq_stat_r <= (irq_stat_r & ~wdata_r[1:0]) | ev;
         end else begin
            irq_stat_r <= irq_stat_r | ev;
         end
         if (do_wr && awaddr_r == A_IRQ_MASK && s_axi_wstrb[0]) begin
            irq_mask_r <= wdata_r[1:0];
         end
      end
   end

   // Read path, one cycle answer
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         case (s_axi_araddr)
            A_FRAME: s_axi_rdata <= {8'h00, frame_r};
            A_STATUS: s_axi_rdata <= {18'h0, last_status_r, busy_r};
            A_IRQ_STAT: s_axi_rdata <= {30'h0, irq_stat_r};
            A_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask_r};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule

// ---- dv/ctrl_link_assertions.sv ----
// Checker: frame link and main control register relations
`timescale 1ns/1ps
module ctrl_link_assertions (
   input wire logic sys_clk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic frame_valid, // Frame strobe
   input wire logic [23:0] frame, // Frame word
   input wire logic frame_ready, // Device ready
   input wire logic [12:0] status_word, // Readback word
   input wire logic status_valid, // Readback strobe
   input wire logic poc_pin, // Power-on pin
   input wire logic [12:0] main_ctrl, // Main control
   input wire logic [3:0] chan_idle_level, // Idle levels
   input wire logic [3:0] chan_out_en, // Output enables
   input wire logic [3:0] chan_conv_pwr, // Converter power
   input wire logic status_rb_en, // Readback enable
   input wire logic watchdog_en, // Watchdog enable
   input wire logic short_limit_8ma, // Limit select
   input wire logic [31:0] watchdog_cycles // Timeout
);
   import ctrl_frame_pkg::*;
   // Control-space frame accepted for the main register
   wire acc = frame_valid && frame_ready && !frame[RW_BIT] && frame[22:21] == 2'h0;
   wire mn = acc && frame[20:18] == GRP_CONTROL && frame[15:13] == SEL_MAIN;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   AST_READY: assert property (frame_ready)
      else $error("frame ready dropped");
   AST_MAIN: assert property (mn |=> main_ctrl == ($past(frame[12:0]) & MC_WMASK))
      else $error("main control not loaded");
   // Any frame but a main write must leave the register alone
   AST_KEEP: assert property (frame_valid && !mn |=> $stable(main_ctrl))
      else $error("main control changed");
   AST_RST: assert property ($rose(nrst) |-> main_ctrl == MC_RESET)
      else $error("main control not cleared");
   AST_STAT: assert property (mn |=> status_valid == $past(main_ctrl[MC_STATUS_RB]))
      else $error("status strobe wrong");
   AST_SWORD: assert property (
      mn && main_ctrl[MC_STATUS_RB] |=> status_word == $past(main_ctrl))
      else $error("status word wrong");
   // Readback strobe only follows a frame sent while readback was on
   AST_STRB: assert property (
      status_valid |-> $past(frame_valid) && $past(main_ctrl[MC_STATUS_RB]))
      else $error("status strobe without frame");
   // Pin passes a two-stage sync, so allow settling first
   AST_IDLE: assert property (
      ($stable(poc_pin) && $stable(main_ctrl))[*4] ##0 $past(nrst, 5)
      |-> chan_idle_level == {4{poc_pin ^ main_ctrl[MC_POLARITY]}})
      else $error("idle level wrong");
   AST_OUT: assert property (
      main_ctrl[MC_OUT_ALL] && $past(main_ctrl[MC_OUT_ALL]) |-> &chan_out_en)
      else $error("outputs not all enabled");
   AST_CONV: assert property (
      main_ctrl[MC_CONV_ALL] && $past(main_ctrl[MC_CONV_ALL]) |-> &chan_conv_pwr)
      else $error("converters not all powered");
   AST_WD: assert property (
      watchdog_cycles == CYC_PER_MS * (main_ctrl[9:8] == 2'h0 ? WD_MS_0 :
      main_ctrl[9:8] == 2'h1 ? WD_MS_1 : main_ctrl[9:8] == 2'h2 ? WD_MS_2 : WD_MS_3))
      else $error("watchdog period wrong");
   AST_BITS: assert property (
      {status_rb_en, watchdog_en, short_limit_8ma} ==
      {main_ctrl[MC_STATUS_RB], main_ctrl[MC_WD_EN], main_ctrl[MC_SHORT_LIM]})
      else $error("control bits wrong");
endmodule

// ---- dv/control_register_decode_main_ctrl_bench.sv ----
// Bench: host and device ends joined, driven over AXI4-Lite
`timescale 1ns/1ps
module control_register_decode_main_ctrl_bench;
   import ctrl_frame_pkg::*;
   logic sys_clk = 0, nrst = 0, poc_pin = 0, irq;
   logic [3:0] awaddr = 0, araddr = 0, idle, oen, cpw;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [31:0] wdata = 0, rdata, q, wdc;
   logic awready, wready, bvalid, arready, rvalid, rbe, wde, sl8;
   logic [1:0] bresp, rresp;
   logic [12:0] mc, cnv, sw, slew [4], dac [4];
   int mismatches = 0, samples_checked = 0, i;
   int ms [4] = '{5, 10, 100, 200};
   ctrl_frame_if lk();
   ctrl_reg_decode u_ctrl_reg_decode (.sys_clk(sys_clk), .nrst(nrst), .link(lk),
      .poc_pin(poc_pin), .chan_idle_level(idle), .chan_out_en(oen), .chan_conv_pwr(cpw),
      .main_ctrl(mc), .status_rb_en(rbe), .watchdog_en(wde), .watchdog_cycles(wdc),
      .short_limit_8ma(sl8), .slew_r(slew), .dac_ctrl_r(dac), .converter_r(cnv),
      .software_r(sw));
   ctrl_frame_host u_ctrl_frame_host (.sys_clk(sys_clk), .nrst(nrst), .link(lk),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .irq(irq));
   ctrl_link_assertions u_ctrl_link_assertions (.sys_clk(sys_clk), .nrst(nrst),
      .frame_valid(lk.frame_valid), .frame(lk.frame), .frame_ready(lk.frame_ready),
      .status_word(lk.status_word), .status_valid(lk.status_valid), .poc_pin(poc_pin),
      .main_ctrl(mc), .chan_idle_level(idle), .chan_out_en(oen), .chan_conv_pwr(cpw),
      .status_rb_en(rbe), .watchdog_en(wde), .short_limit_8ma(sl8), .watchdog_cycles(wdc));
   // 40 MHz clock
   initial begin
      forever #12.5 sys_clk = ~sys_clk;
   end
   task summarize();
      $display("compares %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Hold each channel until its own ready; bready until bvalid
   task wr(input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
         if (bvalid) break;
      end
      bready <= 0;
      chk(bresp, 32'h0);
      if (n == 50) begin mismatches++; summarize(); end
   endtask
   task rd(input logic [3:0] a);
      int n;
      @(posedge sys_clk);
      araddr <= a; arvalid <= 1; rready <= 1;
      for (n = 0; n < 50; n++) begin
         @(posedge sys_clk);
         if (arready) arvalid <= 0;
         if (rvalid) break;
      end
      q = rdata;
      chk(rresp, 32'h0);
      rready <= 0;
      if (n == 50) begin mismatches++; summarize(); end
   endtask
   // Frame goes out in the same cycle as the response; wait for it to land
   task fw(input logic [2:0] s, input logic [1:0] ch, input logic [12:0] d,
      input logic [2:0] g = GRP_CONTROL);
      wr(A_FRAME, {8'h00, 1'b0, 2'h0, g, ch, s, d});
      repeat (3) @(posedge sys_clk);
   endtask
   initial begin
      repeat (10) @(posedge sys_clk);
      nrst <= 1;
      repeat (3) @(posedge sys_clk);
      chk(mc, 32'h0);
      chk(wdc, ms[0] * CYC_PER_MS);
      chk(idle, 32'h0);
      $display("reset test done");
      wr(A_IRQ_MASK, 32'h1);
      fw(SEL_MAIN, 2'h0, 13'h1FFF);
      chk(mc, 32'h1F70);
      chk({rbe, wde, sl8}, 32'h7);
      chk(oen, 32'hF);
      chk(cpw, 32'hF);
      chk(irq, 32'h1);
      repeat (5) @(posedge sys_clk);
      chk(idle, 32'hF);
      poc_pin <= 1;
      repeat (5) @(posedge sys_clk);
      chk(idle, 32'h0);
      wr(A_IRQ_STAT, 32'h1);
      repeat (2) @(posedge sys_clk);
      chk(irq, 32'h0);
      $display("main test done");
      fw(SEL_MAIN, 2'h0, 13'h1F50);
      chk(oen, 32'h0);
      chk(cpw, 32'hF);
      fw(SEL_MAIN, 2'h0, 13'h0800);
      chk(idle, 32'hF);
      rd(A_STATUS);
      chk(q[13:1], 32'h1F50);
      for (i = 0; i < 4; i++) begin
         fw(SEL_MAIN, 2'h0, 13'(i << 8));
         chk(wdc, ms[i] * CYC_PER_MS);
      end
      $display("watchdog test done");
      fw(SEL_MAIN, 2'h0, 13'h1FFF, 3'h6);
      chk(mc, 32'h0300);
      // Read frame and frame for another device address must both be ignored
      wr(A_FRAME, 32'h009C_3FFF);
      wr(A_FRAME, 32'h003C_3FFF);
      repeat (3) @(posedge sys_clk);
      chk(mc, 32'h0300);
      rd(A_FRAME);
      chk(q, 32'h003C_3FFF);
      for (i = 5; i < 8; i++) begin
         fw(3'(i), 2'h0, 13'h1FFF);
         chk({mc, sw}, 32'h0300 << 13);
         chk({cnv, dac[0]}, 32'h0);
      end
      fw(SEL_DAC_CTRL, 2'h2, 13'h0030);
      chk({dac[2], dac[1]}, 32'h0030 << 13);
      chk(oen, 32'h4);
      chk(cpw, 32'h4);
      fw(SEL_SLEW, 2'h1, 13'h00AB);
      fw(SEL_CONVERTER, 2'h0, 13'h0123);
      fw(SEL_SOFTWARE, 2'h0, 13'h0456);
      chk({slew[1], cnv}, {13'h00AB, 13'h0123});
      chk(sw, 32'h0456);
      $display("decode test done");
      summarize();
   end
endmodule
